// ==== gpcfg_params.svh ====
// Offsets, reset values and timing counts of the pad configuration bank.
`ifndef GPCFG_PARAMS_SVH
`define GPCFG_PARAMS_SVH

// Register byte offsets on the register port.
`define GPCFG_OFF_ALT        12'h420
`define GPCFG_OFF_DRV_LOW    12'h500
`define GPCFG_OFF_DRV_MID    12'h504
`define GPCFG_OFF_DRV_HIGH   12'h508
`define GPCFG_OFF_OPEN_DRAIN 12'h50C
`define GPCFG_OFF_PULL_UP    12'h510
`define GPCFG_OFF_PULL_DOWN  12'h514

// Field position of the per-pin bits inside each register word.
`define GPCFG_FIELD_MSB      7
`define GPCFG_FIELD_LSB      0

// Reset values of the alternate-function field per port flavour.
`define GPCFG_RST_ALT_PLAIN  8'h00
`define GPCFG_RST_ALT_PORT_B 8'h80
`define GPCFG_RST_ALT_PORT_C 8'h0F

// Reset values of the remaining fields.
`define GPCFG_RST_DRV_LOW    8'hFF
`define GPCFG_RST_DRV_MID    8'h00
`define GPCFG_RST_DRV_HIGH   8'h00
`define GPCFG_RST_OPEN_DRAIN 8'h00
`define GPCFG_RST_PULL_UP    8'hFF
`define GPCFG_RST_PULL_DOWN  8'h00

// Cycle after a write at which an automatic companion clear is seen.
`define GPCFG_CLEAR_LAG      2

`endif

// ==== gpcfg_pkg.sv ====
// Types shared by the pad configuration bank modules.
`default_nettype none
package gpcfg_pkg;

  // Register selected by an access on the register port.
  typedef enum logic [2:0] {
    GPCFG_SEL_NONE,
    GPCFG_SEL_ALT,
    GPCFG_SEL_DRV_LOW,
    GPCFG_SEL_DRV_MID,
    GPCFG_SEL_DRV_HIGH,
    GPCFG_SEL_OPEN_DRAIN,
    GPCFG_SEL_PULL_UP,
    GPCFG_SEL_PULL_DOWN
  } gpcfg_sel_t;

endpackage : gpcfg_pkg
`default_nettype wire

// ==== gpcfg_pad_if.sv ====
// Interface between the register bank and the pad drive logic.
`timescale 1ns/1ps
`default_nettype none
interface gpcfg_pad_if #(parameter int NPINS = 8);
  logic [NPINS-1:0] alt_sel;
  logic [NPINS-1:0] od_sel;
  logic [NPINS-1:0] dir;
  logic [NPINS-1:0] data;
  logic [NPINS-1:0] alt_oe;
  logic [NPINS-1:0] alt_data;
  logic [NPINS-1:0] pad_oe;
  logic [NPINS-1:0] pad_out;

  // Register side supplies settings and reads back the pad drive.
  modport cfg (output alt_sel, od_sel, dir, data, alt_oe, alt_data,
               input pad_oe, pad_out);
  // Pad side turns the settings into the pad drive.
  modport pad (input alt_sel, od_sel, dir, data, alt_oe, alt_data,
               output pad_oe, pad_out);
endinterface : gpcfg_pad_if
`default_nettype wire

// ==== gpcfg_pad_drive.sv ====
// Per-pin pad drive: pin ownership mux and open-drain conversion.
`timescale 1ns/1ps
`default_nettype none
module gpcfg_pad_drive
  import gpcfg_pkg::*;
#(
  parameter int NPINS = 8
) (
  input  wire logic clock,
  input  wire logic reset_n,
  gpcfg_pad_if.pad  pif
);

  ////////////////////////////////////////////////////////////////////////
  // One drive stage per pin; outputs are registered for the pad ring.
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      logic src_oe;
      logic src_data;

      // Alternate function owns the pin when its select bit is set.
      assign src_oe   = pif.alt_sel[g] ? pif.alt_oe[g] : pif.dir[g];
      assign src_data = pif.alt_sel[g] ? pif.alt_data[g] : pif.data[g];

      // Open drain only ever pulls low; an input pin never drives.
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          pif.pad_oe[g]  <= 1'b0;
          pif.pad_out[g] <= 1'b0;
        end else if (pif.od_sel[g]) begin
          pif.pad_oe[g]  <= src_oe & ~src_data;
          pif.pad_out[g] <= 1'b0;
        end else begin
          pif.pad_oe[g]  <= src_oe;
          pif.pad_out[g] <= src_data;
        end
      end
    end
  endgenerate

endmodule : gpcfg_pad_drive
`default_nettype wire

// ==== gpcfg_bank.sv ====
// Pad configuration register bank for one eight-pin I/O port.
//
// Summary of operation
// - Each pin has an alternate-function bit; 1 hands the pin to hardware.
// - Alternate field resets to 0x00, port B to 0x80, port C to 0x0F.
// - Bits 31 to 8 of every register are read-only; software leaves them.
// - Writing 1 to a 2-mA bit clears that pin's 4-mA and 8-mA bits.
// - Writing 1 to a 4-mA bit clears that pin's 2-mA and 8-mA bits.
// - Writing 1 to an 8-mA bit clears that pin's 2-mA and 4-mA bits.
// - An automatic companion clear shows on the second cycle after the write.
// - Drive fields reset to 2-mA on every pin: 0xFF, 0x00, 0x00.
// - Each drive bit affects only its own pin.
// - One open-drain enable bit per pin, reset to 0x00.
// - Open-drain pin acts as input when direction is 0, output when 1.
// - Pull-up bit enables weak pull-up, resets 0xFF, clears pull-down.
// - Pull-down bit enables weak pull-down, resets 0x00, clears pull-up.
// - Any reset returns every pin, debug pins too, to default alternate.
`timescale 1ns/1ps
`default_nettype none
`include "gpcfg_params.svh"
module gpcfg_bank
  import gpcfg_pkg::*;
#(
  parameter int         NPINS     = 8,
  parameter logic [7:0] ALT_RESET = `GPCFG_RST_ALT_PLAIN
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [11:0]      reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output var  logic [31:0]      reg_rdata,
  input  wire logic [NPINS-1:0] dir_bits,
  input  wire logic [NPINS-1:0] out_bits,
  input  wire logic [NPINS-1:0] alt_oe_bits,
  input  wire logic [NPINS-1:0] alt_out_bits,
  output logic      [NPINS-1:0] alt_func_bits,
  output logic      [NPINS-1:0] drive_low_bits,
  output logic      [NPINS-1:0] drive_mid_bits,
  output logic      [NPINS-1:0] drive_high_bits,
  output logic      [NPINS-1:0] open_drain_bits,
  output logic      [NPINS-1:0] pull_up_bits,
  output logic      [NPINS-1:0] pull_down_bits,
  output logic      [NPINS-1:0] pad_oe,
  output logic      [NPINS-1:0] pad_out
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations.
  gpcfg_sel_t       addr_sel;
  gpcfg_sel_t       wr_sel;
  gpcfg_sel_t       pend_sel_r;
  logic [NPINS-1:0] pend_mask_r;
  logic [NPINS-1:0] wr_bits;
  logic [NPINS-1:0] alt_r;
  logic [NPINS-1:0] drv_low_r;
  logic [NPINS-1:0] drv_mid_r;
  logic [NPINS-1:0] drv_high_r;
  logic [NPINS-1:0] od_r;
  logic [NPINS-1:0] pu_r;
  logic [NPINS-1:0] pd_r;
  logic [NPINS-1:0] drv_low_nxt;
  logic [NPINS-1:0] drv_mid_nxt;
  logic [NPINS-1:0] drv_high_nxt;
  logic [NPINS-1:0] pu_nxt;
  logic [NPINS-1:0] pd_nxt;
  logic [NPINS-1:0] rd_field;
  logic [31:0]      rdata_r;

  gpcfg_pad_if #(.NPINS(NPINS)) pif ();

  ////////////////////////////////////////////////////////////////////////
  // Address decode. Unmapped offsets select nothing and read as zero.
  always_comb begin
    case (reg_addr)
      `GPCFG_OFF_ALT:        addr_sel = GPCFG_SEL_ALT;
      `GPCFG_OFF_DRV_LOW:    addr_sel = GPCFG_SEL_DRV_LOW;
      `GPCFG_OFF_DRV_MID:    addr_sel = GPCFG_SEL_DRV_MID;
      `GPCFG_OFF_DRV_HIGH:   addr_sel = GPCFG_SEL_DRV_HIGH;
      `GPCFG_OFF_OPEN_DRAIN: addr_sel = GPCFG_SEL_OPEN_DRAIN;
      `GPCFG_OFF_PULL_UP:    addr_sel = GPCFG_SEL_PULL_UP;
      `GPCFG_OFF_PULL_DOWN:  addr_sel = GPCFG_SEL_PULL_DOWN;
      default:               addr_sel = GPCFG_SEL_NONE;
    endcase
  end

  // Only the low field of the write word is stored; upper bits are dropped.
  assign wr_sel  = reg_wr ? addr_sel : GPCFG_SEL_NONE;
  assign wr_bits = reg_wdata[`GPCFG_FIELD_MSB:`GPCFG_FIELD_LSB];

  ////////////////////////////////////////////////////////////////////////
  // Companion clears wait one extra cycle in this pending stage, so the
  // written bit is seen one cycle after the write and the companion clear
  // one cycle later. Only bits written as 1 are scheduled.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pend_sel_r  <= GPCFG_SEL_NONE;
      pend_mask_r <= '0;
    end else begin
      pend_sel_r  <= wr_sel;
      pend_mask_r <= wr_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alternate-function select. Every reset restores the port's default.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      alt_r <= ALT_RESET;
    end else if (wr_sel == GPCFG_SEL_ALT) begin
      alt_r <= wr_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next values of the three drive fields. A pending clear from another
  // drive field applies first, and a write in the same cycle wins over it.
  always_comb begin
    drv_low_nxt  = drv_low_r;
    drv_mid_nxt  = drv_mid_r;
    drv_high_nxt = drv_high_r;
    case (pend_sel_r)
      GPCFG_SEL_DRV_LOW: begin
        drv_mid_nxt  = drv_mid_r & ~pend_mask_r;
        drv_high_nxt = drv_high_r & ~pend_mask_r;
      end
      GPCFG_SEL_DRV_MID: begin
        drv_low_nxt  = drv_low_r & ~pend_mask_r;
        drv_high_nxt = drv_high_r & ~pend_mask_r;
      end
      GPCFG_SEL_DRV_HIGH: begin
        drv_low_nxt  = drv_low_r & ~pend_mask_r;
        drv_mid_nxt  = drv_mid_r & ~pend_mask_r;
      end
      default: begin
        drv_low_nxt  = drv_low_r;
      end
    endcase
    if (wr_sel == GPCFG_SEL_DRV_LOW) begin
      drv_low_nxt = wr_bits;
    end
    if (wr_sel == GPCFG_SEL_DRV_MID) begin
      drv_mid_nxt = wr_bits;
    end
    if (wr_sel == GPCFG_SEL_DRV_HIGH) begin
      drv_high_nxt = wr_bits;
    end
  end

  // Drive fields; every pin starts at the lowest drive strength.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      drv_low_r  <= `GPCFG_RST_DRV_LOW;
      drv_mid_r  <= `GPCFG_RST_DRV_MID;
      drv_high_r <= `GPCFG_RST_DRV_HIGH;
    end else begin
      drv_low_r  <= drv_low_nxt;
      drv_mid_r  <= drv_mid_nxt;
      drv_high_r <= drv_high_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Open-drain enables, one per pin.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      od_r <= `GPCFG_RST_OPEN_DRAIN;
    end else if (wr_sel == GPCFG_SEL_OPEN_DRAIN) begin
      od_r <= wr_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next values of the pull fields; pull-up and pull-down exclude each
  // other per pin with the same delayed clear as the drive fields.
  always_comb begin
    pu_nxt = pu_r;
    pd_nxt = pd_r;
    if (pend_sel_r == GPCFG_SEL_PULL_UP) begin
      pd_nxt = pd_r & ~pend_mask_r;
    end
    if (pend_sel_r == GPCFG_SEL_PULL_DOWN) begin
      pu_nxt = pu_r & ~pend_mask_r;
    end
    if (wr_sel == GPCFG_SEL_PULL_UP) begin
      pu_nxt = wr_bits;
    end
    if (wr_sel == GPCFG_SEL_PULL_DOWN) begin
      pd_nxt = wr_bits;
    end
  end

  // Pull fields; every pin starts with its weak pull-up on.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pu_r <= `GPCFG_RST_PULL_UP;
      pd_r <= `GPCFG_RST_PULL_DOWN;
    end else begin
      pu_r <= pu_nxt;
      pd_r <= pd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path. Data stand only in the cycle after the read strobe; the
  // upper bits, whose value software may not rely on, read as zero.
  always_comb begin
    case (addr_sel)
      GPCFG_SEL_ALT:        rd_field = alt_r;
      GPCFG_SEL_DRV_LOW:    rd_field = drv_low_r;
      GPCFG_SEL_DRV_MID:    rd_field = drv_mid_r;
      GPCFG_SEL_DRV_HIGH:   rd_field = drv_high_r;
      GPCFG_SEL_OPEN_DRAIN: rd_field = od_r;
      GPCFG_SEL_PULL_UP:    rd_field = pu_r;
      GPCFG_SEL_PULL_DOWN:  rd_field = pd_r;
      default:              rd_field = '0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      rdata_r <= {{(32 - NPINS){1'b0}}, rd_field};
    end else begin
      rdata_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output connections, each straight from its flip-flop.
  assign reg_rdata       = rdata_r;
  assign alt_func_bits   = alt_r;
  assign drive_low_bits  = drv_low_r;
  assign drive_mid_bits  = drv_mid_r;
  assign drive_high_bits = drv_high_r;
  assign open_drain_bits = od_r;
  assign pull_up_bits    = pu_r;
  assign pull_down_bits  = pd_r;

  ////////////////////////////////////////////////////////////////////////
  // Pad drive stage. Direction and data come from the same clock domain.
  assign pif.alt_sel  = alt_r;
  assign pif.od_sel   = od_r;
  assign pif.dir      = dir_bits;
  assign pif.data     = out_bits;
  assign pif.alt_oe   = alt_oe_bits;
  assign pif.alt_data = alt_out_bits;
  assign pad_oe       = pif.pad_oe;
  assign pad_out      = pif.pad_out;

  gpcfg_pad_drive #(
    .NPINS (NPINS)
  ) u_pad_drive (
    .clock   (clock),
    .reset_n (reset_n),
    .pif     (pif.pad)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks of the bank's behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // A single write to a given register.
  sequence s_wr_low;
    reg_wr && reg_addr == `GPCFG_OFF_DRV_LOW;
  endsequence
  sequence s_wr_mid;
    reg_wr && reg_addr == `GPCFG_OFF_DRV_MID;
  endsequence
  sequence s_wr_high;
    reg_wr && reg_addr == `GPCFG_OFF_DRV_HIGH;
  endsequence
  sequence s_wr_pu;
    reg_wr && reg_addr == `GPCFG_OFF_PULL_UP;
  endsequence

  // A written alternate field is stored one cycle later.
  property p_alt_store;
    logic [7:0] v;
    (reg_wr && reg_addr == `GPCFG_OFF_ALT, v = reg_wdata[7:0])
      |=> alt_func_bits == v;
  endproperty
  a_alt_store: assert property (p_alt_store)
    else $error("alternate field not stored");

  // Reset loads the port's default alternate field and drive settings.
  property p_reset_values;
    @(posedge clock) disable iff (1'b0)
      !reset_n |=> (alt_func_bits == ALT_RESET)
      && drive_low_bits == 8'hFF && drive_mid_bits == 8'h00
      && drive_high_bits == 8'h00;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("wrong reset value");

  // Read data carry no upper bits and vanish after one cycle.
  property p_read_word;
    reg_rd |=> reg_rdata[31:8] == 24'h000000 ##1 (reg_rd || $past(reg_rd)
      || reg_rdata == 32'h00000000);
  endproperty
  a_read_word: assert property (p_read_word)
    else $error("read word malformed");

  // A 2-mA write of 1 clears the other drive bits two cycles on.
  property p_low_excl;
    logic [7:0] m;
    (s_wr_low, m = reg_wdata[7:0]) ##1 !reg_wr
      |=> ((drive_mid_bits | drive_high_bits) & m) == 8'h00;
  endproperty
  a_low_excl: assert property (p_low_excl)
    else $error("2-mA write did not clear companions");

  // A 4-mA write of 1 clears the other drive bits two cycles on.
  property p_mid_excl;
    logic [7:0] m;
    (s_wr_mid, m = reg_wdata[7:0]) ##1 !reg_wr
      |=> ((drive_low_bits | drive_high_bits) & m) == 8'h00;
  endproperty
  a_mid_excl: assert property (p_mid_excl)
    else $error("4-mA write did not clear companions");

  // An 8-mA write of 1 clears the other drive bits two cycles on.
  property p_high_excl;
    logic [7:0] m;
    (s_wr_high, m = reg_wdata[7:0]) ##1 !reg_wr
      |=> ((drive_low_bits | drive_mid_bits) & m) == 8'h00;
  endproperty
  a_high_excl: assert property (p_high_excl)
    else $error("8-mA write did not clear companions");

  // The companion clear is not yet visible in the first cycle.
  property p_clear_lag;
    s_wr_mid ##0 pend_sel_r == GPCFG_SEL_NONE
      |=> drive_low_bits == $past(drive_low_bits);
  endproperty
  a_clear_lag: assert property (p_clear_lag)
    else $error("companion cleared too early");

  // Pins written as 0 in a 2-mA write keep their 4-mA drive bits.
  property p_zero_keeps;
    logic [7:0] k;
    (s_wr_low, k = ~reg_wdata[7:0]) ##1 !reg_wr
      |=> ((drive_mid_bits ^ $past(drive_mid_bits)) & k) == 8'h00;
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("companion of a zero-written pin changed");

  // Open-drain pin 0, when not under alternate control, never drives high.
  property p_od_low_only;
    (open_drain_bits[0] && !alt_func_bits[0])
      |=> !(pad_oe[0] && pad_out[0]);
  endproperty
  a_od_low_only: assert property (p_od_low_only)
    else $error("open-drain pin drove high");

  // A pull-up write of 1 clears the pull-down bit two cycles on.
  property p_pull_excl;
    logic [7:0] m;
    (s_wr_pu, m = reg_wdata[7:0]) ##1 !reg_wr
      |=> (pull_down_bits & m) == 8'h00;
  endproperty
  a_pull_excl: assert property (p_pull_excl)
    else $error("pull-up write did not clear pull-down");

  // Pull-up and pull-down stay exclusive once both settled quietly.
  property p_pull_settled;
    (!reg_wr)[*3] |-> (pull_up_bits & pull_down_bits) == 8'h00;
  endproperty
  a_pull_settled: assert property (p_pull_settled)
    else $error("pull-up and pull-down both on");

  // Open-drain enables follow a write one cycle later.
  property p_od_store;
    logic [7:0] v;
    (reg_wr && reg_addr == `GPCFG_OFF_OPEN_DRAIN, v = reg_wdata[7:0])
      |=> open_drain_bits == v;
  endproperty
  a_od_store: assert property (p_od_store)
    else $error("open-drain field not stored");

endmodule : gpcfg_bank
`default_nettype wire

// ==== gpcfg_alt_model.sv ====
// Model of the alternate peripheral that takes pins under hardware control.
`timescale 1ns/1ps
`default_nettype none
module gpcfg_alt_model (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [7:0] oe_req,
  input  wire logic [7:0] out_req,
  output var  logic [7:0] alt_oe_bits,
  output var  logic [7:0] alt_out_bits
);
  // The peripheral drives its pin requests from its own flops, one cycle late.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      alt_oe_bits  <= 8'h00;
      alt_out_bits <= 8'h00;
    end else begin
      alt_oe_bits  <= oe_req;
      alt_out_bits <= out_req;
    end
  end
endmodule : gpcfg_alt_model
`default_nettype wire

// ==== gpcfg_tb.sv ====
// Self-checking testbench of the pad configuration bank.
`timescale 1ns/1ps
`default_nettype none
`include "gpcfg_params.svh"
module testbench;
  import gpcfg_pkg::*;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [55:0] cfg;
    logic [31:0] rd;
  } gpcfg_row_t;

  logic        clock, reset_n, reg_wr, reg_rd;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [7:0]  dir_bits, out_bits, oe_req, out_req, alt_oe_bits, alt_out_bits;
  logic [7:0]  alt_func_bits, drive_low_bits, drive_mid_bits, drive_high_bits;
  logic [7:0]  open_drain_bits, pull_up_bits, pull_down_bits;
  logic [7:0]  pad_oe, pad_out, c_alt;
  int          fails, n_checks;

  // Register offsets and reset values read back after the first reset.
  logic [11:0] rst_addr [0:6] = '{`GPCFG_OFF_ALT, `GPCFG_OFF_DRV_LOW,
    `GPCFG_OFF_DRV_MID, `GPCFG_OFF_DRV_HIGH, `GPCFG_OFF_OPEN_DRAIN,
    `GPCFG_OFF_PULL_UP, `GPCFG_OFF_PULL_DOWN};
  logic [7:0]  rst_val [0:6] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF,
    8'h00};
  // Each row: write, then all fields {alt,2mA,4mA,8mA,od,pu,pd} and readback.
  gpcfg_row_t rows [0:10] = '{
    '{`GPCFG_OFF_DRV_MID,    32'h01, 56'h007E010000FF00, 32'h01},
    '{`GPCFG_OFF_DRV_HIGH,   32'h02, 56'h007C010200FF00, 32'h02},
    '{`GPCFG_OFF_DRV_LOW,    32'h03, 56'h0003000000FF00, 32'h03},
    '{`GPCFG_OFF_DRV_MID,    32'hF0, 56'h0003F00000FF00, 32'hF0},
    '{`GPCFG_OFF_DRV_MID,    32'h00, 56'h0003000000FF00, 32'h00},
    '{`GPCFG_OFF_PULL_DOWN,  32'h0F, 56'h0003000000F00F, 32'h0F},
    '{`GPCFG_OFF_PULL_UP,    32'h01, 56'h0003000000010E, 32'h01},
    '{`GPCFG_OFF_PULL_UP,    32'h00, 56'h0003000000000E, 32'h00},
    // software sets its digital input enable outside this bank.
    '{`GPCFG_OFF_OPEN_DRAIN, 32'hFFFFFFA5, 56'h00030000A5000E, 32'hA5},
    '{`GPCFG_OFF_ALT,        32'h0C, 56'h0C030000A5000E, 32'h0C},
    '{12'h518,               32'hFF, 56'h0C030000A5000E, 32'h00}};

  gpcfg_bank i_dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dir_bits(dir_bits), .out_bits(out_bits),
    .alt_oe_bits(alt_oe_bits), .alt_out_bits(alt_out_bits),
    .alt_func_bits(alt_func_bits), .drive_low_bits(drive_low_bits),
    .drive_mid_bits(drive_mid_bits), .drive_high_bits(drive_high_bits),
    .open_drain_bits(open_drain_bits), .pull_up_bits(pull_up_bits),
    .pull_down_bits(pull_down_bits), .pad_oe(pad_oe), .pad_out(pad_out));
  // Port C flavour shares the bus so its debug pin defaults can be watched.
  gpcfg_bank #(.ALT_RESET(`GPCFG_RST_ALT_PORT_C)) i_dut_c (.clock(clock),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .dir_bits(dir_bits),
    .out_bits(out_bits), .alt_oe_bits(alt_oe_bits),
    .alt_out_bits(alt_out_bits), .alt_func_bits(c_alt), .drive_low_bits(),
    .drive_mid_bits(), .drive_high_bits(), .open_drain_bits(),
    .pull_up_bits(), .pull_down_bits(), .pad_oe(), .pad_out());
  gpcfg_alt_model i_alt (.clock(clock), .reset_n(reset_n), .oe_req(oe_req),
    .out_req(out_req), .alt_oe_bits(alt_oe_bits),
    .alt_out_bits(alt_out_bits));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 50 ns period.
  always #25 clock = ~clock;

  // Compares one value and counts the comparison and any mismatch.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle write strobe beside address and data.
  task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : bus_write

  // One-cycle read strobe; the data are taken in the following cycle.
  task automatic bus_read(input logic [11:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : bus_read

  // Pad drive worked out from pin ownership and open-drain setting.
  function automatic logic [15:0] pad_exp(input logic [7:0] alt, od, dir,
                                          out, aoe, aout);
    logic [7:0] soe, sd;
    soe = (alt & aoe) | (~alt & dir);
    sd  = (alt & aout) | (~alt & out);
    return {(od & soe & ~sd) | (~od & soe), ~od & sd};
  endfunction : pad_exp

  // Prints the verdict and ends the run.
  task automatic finish_test;
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog cuts a hang short well past the expected run of some 160 cycles.
  initial begin
    #100000;
    fails++;
    finish_test();
  end

  // Main sequence: reset values, companion timing, rows, pads, second reset.
  initial begin
    clock = 1'b0; reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 12'h000; reg_wdata = 32'h0; dir_bits = 8'h00;
    out_bits = 8'h00; oe_req = 8'h00; out_req = 8'h00;
    fails = 0; n_checks = 0;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      bus_read(rst_addr[i], rd);
      check(rd, {24'h0, rst_val[i]});
    end
    check(c_alt, `GPCFG_RST_ALT_PORT_C);
    bus_write(`GPCFG_OFF_DRV_MID, 32'h80);
    #1 check({drive_mid_bits, drive_low_bits}, 16'h80FF);
    @(posedge clock);
    #1 check({drive_mid_bits, drive_low_bits}, 16'h807F);
    foreach (rows[i]) begin
      bus_write(rows[i].addr, rows[i].wdata);
      @(posedge clock);
      #1 check({alt_func_bits, drive_low_bits, drive_mid_bits,
                drive_high_bits, open_drain_bits, pull_up_bits,
                pull_down_bits}, rows[i].cfg);
      bus_read(rows[i].addr, rd);
      check(rd, rows[i].rd);
    end
    check(c_alt, 8'h0C);
    for (int k = 0; k < 16; k++) begin
      @(posedge clock);
      dir_bits <= 8'h33 ^ {8{k[0]}};
      out_bits <= 8'h55 ^ {8{k[1]}};
      oe_req   <= 8'h0F ^ {8{k[2]}};
      out_req  <= 8'h99 ^ {8{k[3]}};
      repeat (3) @(posedge clock);
      #1 check({pad_oe, pad_out}, pad_exp(8'h0C, 8'hA5, dir_bits, out_bits,
               oe_req, out_req));
    end
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1 check({alt_func_bits, drive_low_bits, drive_mid_bits, drive_high_bits,
              open_drain_bits, pull_up_bits, pull_down_bits},
             56'h00FF000000FF00);
    check(c_alt, `GPCFG_RST_ALT_PORT_C);
    check({pad_oe, pad_out}, 16'h0000);
    @(posedge clock);
    reset_n <= 1'b1;
    // The bank answers reads right after the second release of reset.
    bus_read(`GPCFG_OFF_DRV_LOW, rd);
    check(rd, 32'h000000FF);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
